// *** shield_pkg.sv ***
// Constants and types for the flash shield window guard.
// Assumes a single 50 MHz clock and byte addresses into on-chip flash.
package shield_pkg;
  localparam int ADDR_W = 20;
  localparam int BLOCK_W = 8;
  // One block is 1 KiB, so the block number starts at address bit ten
  localparam int BLOCK_LSB = 10;
  localparam logic [ADDR_W-1:0] OPT_PRIMARY_BASE = 20'h000C0;
  localparam logic [ADDR_W-1:0] OPT_SWAP_BASE = 20'h010C0;
  localparam logic [1:0] OPT_LAST_INDEX = 2'h3;
  localparam logic [BLOCK_W-1:0] WIN_START_RESET = 8'h00;
  localparam logic [BLOCK_W-1:0] WIN_END_RESET = 8'hFF;
  localparam logic [BLOCK_W-1:0] BOOT0_LAST_RESET = 8'h03;

  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_ERASE = 2'b01,
    CMD_WRITE = 2'b10
  } cmd_type;
endpackage : shield_pkg

// *** flash_shield_window_guard.sv ***
// Flash shield window guard: checks each erase or write command and passes it on or refuses it.
// Assumes the sequencer holds one command for one cycle and the flash array obeys grant only.
module flash_shield_window_guard
  import shield_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic self_prog,
  input wire logic boot_swap,
  input wire logic boot0_protect,
  input wire logic win_set,
  input wire logic [BLOCK_W-1:0] win_start_in,
  input wire logic [BLOCK_W-1:0] win_end_in,
  input wire cmd_type cmd,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [1:0] opt_index,
  output logic grant,
  output logic refuse,
  output logic [ADDR_W-1:0] grant_addr,
  output logic [ADDR_W-1:0] opt_addr,
  output logic [BLOCK_W-1:0] win_start,
  output logic [BLOCK_W-1:0] win_end
);

  logic [BLOCK_W-1:0] target_block;
  logic in_window;
  logic in_boot0;
  logic allowed;

  ////////////////////////////////////////////////////////////////////////////
  // Window registers, written in any mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      win_start <= WIN_START_RESET;
      win_end <= WIN_END_RESET;
    end else if (win_set) begin
      win_start <= win_start_in;
      win_end <= win_end_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command check
  assign target_block = cmd_addr[BLOCK_LSB +: BLOCK_W];
  assign in_window = (target_block >= win_start) && (target_block <= win_end);
  assign in_boot0 = boot0_protect && (target_block <= BOOT0_LAST_RESET);
  // Boot cluster lock applies in every mode, ahead of the window
  assign allowed = !in_boot0 && (!self_prog || in_window);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      grant <= 1'b0;
      refuse <= 1'b0;
      grant_addr <= '0;
    end else begin
      grant <= (cmd != CMD_NONE) && allowed;
      refuse <= (cmd != CMD_NONE) && !allowed;
      grant_addr <= cmd_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option byte fetch address; the alternate copy must match the primary
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opt_addr <= OPT_PRIMARY_BASE;
    end else begin
      opt_addr <= ((self_prog && boot_swap) ? OPT_SWAP_BASE : OPT_PRIMARY_BASE)
        + {{(ADDR_W-2){1'b0}}, opt_index};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_refuse_outside;
    @(posedge clk) disable iff (!nrst)
      (self_prog && cmd != CMD_NONE && !in_window) |=> (refuse && !grant);
  endproperty
  a_refuse_outside: assert property (p_refuse_outside) else $error("outside window granted");

  property p_write_inside;
    @(posedge clk) disable iff (!nrst)
      (self_prog && cmd == CMD_WRITE && in_window && !in_boot0) |=> grant;
  endproperty
  a_write_inside: assert property (p_write_inside) else $error("write inside window refused");

  property p_window_load;
    @(posedge clk) disable iff (!nrst)
      win_set |=> (win_start == $past(win_start_in) && win_end == $past(win_end_in));
  endproperty
  a_window_load: assert property (p_window_load) else $error("window not loaded");

  property p_window_hold;
    @(posedge clk) disable iff (!nrst)
      !win_set |=> $stable(win_start) && $stable(win_end);
  endproperty
  a_window_hold: assert property (p_window_hold) else $error("window changed unasked");

  property p_external_free;
    @(posedge clk) disable iff (!nrst)
      (!self_prog && cmd != CMD_NONE && !in_boot0) |=> grant;
  endproperty
  a_external_free: assert property (p_external_free) else $error("external command refused");

  property p_boot0_wins;
    @(posedge clk) disable iff (!nrst)
      (cmd != CMD_NONE && in_boot0) |=> refuse;
  endproperty
  a_boot0_wins: assert property (p_boot0_wins) else $error("boot cluster rewritten");

  property p_swap_addr;
    @(posedge clk) disable iff (!nrst)
      (self_prog && boot_swap && opt_index == 2'h0) |=> opt_addr == OPT_SWAP_BASE;
  endproperty
  a_swap_addr: assert property (p_swap_addr) else $error("swap option address wrong");

  property p_never_both;
    @(posedge clk) disable iff (!nrst)
      !(grant && refuse);
  endproperty
  a_never_both: assert property (p_never_both) else $error("grant and refuse together");

  ////////////////////////////////////////////////////////////////////////////
  // Reference terms for the checks, written apart from the datapath
  // so a slip in the compare logic cannot vouch for itself
  logic [BLOCK_W-1:0] chk_block;
  logic chk_below;
  logic chk_above;
  logic chk_boot0;
  logic chk_cmd;
  logic [ADDR_W-1:0] chk_opt_base;

  assign chk_block = cmd_addr[BLOCK_LSB+BLOCK_W-1:BLOCK_LSB];
  assign chk_below = chk_block < win_start;
  assign chk_above = chk_block > win_end;
  assign chk_boot0 = boot0_protect && (chk_block < (BOOT0_LAST_RESET + 8'h01));
  assign chk_cmd = cmd != CMD_NONE;
  assign chk_opt_base = (self_prog && boot_swap) ? OPT_SWAP_BASE : OPT_PRIMARY_BASE;

  sequence s_self_cmd;
    self_prog && chk_cmd;
  endsequence

  sequence s_ext_cmd;
    !self_prog && chk_cmd;
  endsequence

  sequence s_granted;
    grant && !refuse;
  endsequence

  sequence s_refused;
    refuse && !grant;
  endsequence

  // New window must already govern the command right after the load
  sequence s_load_then_self_cmd;
    win_set ##1 (s_self_cmd ##0
      (chk_block >= $past(win_start_in) && chk_block <= $past(win_end_in) && !chk_boot0));
  endsequence

  property p_erase_outside;
    @(posedge clk) disable iff (!nrst)
      (s_self_cmd ##0 (cmd == CMD_ERASE && (chk_below || chk_above))) |=> s_refused;
  endproperty
  a_erase_outside: assert property (p_erase_outside) else $error("erase outside window granted");

  property p_erase_inside;
    @(posedge clk) disable iff (!nrst)
      (s_self_cmd ##0 (cmd == CMD_ERASE && !chk_below && !chk_above && !chk_boot0)) |=> s_granted;
  endproperty
  a_erase_inside: assert property (p_erase_inside) else $error("erase inside window refused");

  property p_write_outside;
    @(posedge clk) disable iff (!nrst)
      (s_self_cmd ##0 (cmd == CMD_WRITE && (chk_below || chk_above))) |=> s_refused;
  endproperty
  a_write_outside: assert property (p_write_outside) else $error("write outside window granted");

  property p_load_self;
    @(posedge clk) disable iff (!nrst)
      (self_prog && win_set) |=> (win_start == $past(win_start_in) && win_end == $past(win_end_in));
  endproperty
  a_load_self: assert property (p_load_self) else $error("window not loaded in self programming");

  property p_load_external;
    @(posedge clk) disable iff (!nrst)
      (!self_prog && win_set) |=> (win_start == $past(win_start_in) && win_end == $past(win_end_in));
  endproperty
  a_load_external: assert property (p_load_external) else $error("window not loaded externally");

  property p_new_window_used;
    @(posedge clk) disable iff (!nrst)
      s_load_then_self_cmd |=> s_granted;
  endproperty
  a_new_window_used: assert property (p_new_window_used) else $error("new window not applied");

  property p_ext_outside;
    @(posedge clk) disable iff (!nrst)
      (s_ext_cmd ##0 ((chk_below || chk_above) && !chk_boot0)) |=> s_granted;
  endproperty
  a_ext_outside: assert property (p_ext_outside) else $error("external command outside window refused");

  property p_boot0_self;
    @(posedge clk) disable iff (!nrst)
      (s_self_cmd ##0 chk_boot0) |=> s_refused;
  endproperty
  a_boot0_self: assert property (p_boot0_self) else $error("boot cluster rewritten in self programming");

  property p_boot0_ext;
    @(posedge clk) disable iff (!nrst)
      (s_ext_cmd ##0 chk_boot0) |=> s_refused;
  endproperty
  a_boot0_ext: assert property (p_boot0_ext) else $error("boot cluster rewritten externally");

  property p_opt_follow;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> (opt_addr == $past(chk_opt_base) + {{(ADDR_W-2){1'b0}}, $past(opt_index)});
  endproperty
  a_opt_follow: assert property (p_opt_follow) else $error("option fetch address wrong");

  property p_primary_area;
    @(posedge clk) disable iff (!nrst)
      !(self_prog && boot_swap) |=> (opt_addr[ADDR_W-1:2] == OPT_PRIMARY_BASE[ADDR_W-1:2]);
  endproperty
  a_primary_area: assert property (p_primary_area) else $error("option fetch left primary area");

  property p_start_edge;
    @(posedge clk) disable iff (!nrst)
      (s_self_cmd ##0 (chk_block == win_start && win_start <= win_end && !chk_boot0)) |=> s_granted;
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("start block refused");

  property p_end_edge;
    @(posedge clk) disable iff (!nrst)
      (s_self_cmd ##0 (chk_block == win_end && win_start <= win_end && !chk_boot0)) |=> s_granted;
  endproperty
  a_end_edge: assert property (p_end_edge) else $error("end block refused");

  property p_answer_once;
    @(posedge clk) disable iff (!nrst)
      chk_cmd |=> (grant ^ refuse);
  endproperty
  a_answer_once: assert property (p_answer_once) else $error("command not answered once");

  property p_idle_quiet;
    @(posedge clk) disable iff (!nrst)
      !chk_cmd |=> (!grant && !refuse);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("answer without command");

  property p_addr_passed;
    @(posedge clk) disable iff (!nrst)
      chk_cmd |=> (grant_addr == $past(cmd_addr));
  endproperty
  a_addr_passed: assert property (p_addr_passed) else $error("granted address differs");

endmodule : flash_shield_window_guard

// *** opt_store.sv ***
// Option byte store that answers the guard's fetch address.
// Assumes one byte per address, four bytes per area.
module opt_store
  import shield_pkg::*;
(
  input wire logic [ADDR_W-1:0] opt_addr,
  output logic [7:0] opt_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] IMAGE = 32'h44332211;
  logic hit;
  // Alternate area mirrors the primary, so a swap changes nothing
  assign hit = (opt_addr[ADDR_W-1:2] == OPT_PRIMARY_BASE[ADDR_W-1:2])
    || (opt_addr[ADDR_W-1:2] == OPT_SWAP_BASE[ADDR_W-1:2]);
  assign opt_byte = hit ? IMAGE[opt_addr[1:0]*8 +: 8] : 8'hA5;
endmodule : opt_store

// *** tb_top.sv ***
// Self-checking bench for the flash shield window guard.
// Assumes answers one cycle after each command.
module tb_top
  import shield_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic sp; logic b0; cmd_type c; logic [7:0] blk; logic ok;} row_type;
  logic clk = 0, nrst = 0, self_prog = 0, boot_swap = 0, boot0_protect = 0, win_set = 0;
  logic [7:0] win_start_in = 8'h00, win_end_in = 8'h00, win_start, win_end, opt_byte;
  cmd_type cmd = CMD_NONE;
  logic [19:0] cmd_addr = 20'h00000, grant_addr, opt_addr;
  logic [1:0] opt_index = 2'h0;
  logic grant, refuse;
  int num_errors = 0, compares = 0;
  row_type rows [10] = '{'{1, 0, CMD_ERASE, 8'h02, 1}, '{1, 0, CMD_WRITE, 8'h06, 1},
    '{1, 0, CMD_ERASE, 8'h07, 0}, '{1, 0, CMD_WRITE, 8'h01, 0}, '{0, 0, CMD_ERASE, 8'h09, 1},
    '{0, 0, CMD_WRITE, 8'h08, 1}, '{1, 1, CMD_WRITE, 8'h03, 0}, '{0, 1, CMD_ERASE, 8'h00, 0},
    '{0, 1, CMD_WRITE, 8'h0A, 1}, '{1, 0, CMD_WRITE, 8'h03, 1}};
  flash_shield_window_guard DUT (.clk(clk), .nrst(nrst), .self_prog(self_prog), .boot_swap(boot_swap),
    .boot0_protect(boot0_protect), .win_set(win_set), .win_start_in(win_start_in),
    .win_end_in(win_end_in), .cmd(cmd), .cmd_addr(cmd_addr), .opt_index(opt_index), .grant(grant),
    .refuse(refuse), .grant_addr(grant_addr), .opt_addr(opt_addr), .win_start(win_start),
    .win_end(win_end));
  opt_store store (.opt_addr(opt_addr), .opt_byte(opt_byte));
  task automatic check(string name, logic [19:0] seen, logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1;
    #1 check("win_start", win_start, 20'(WIN_START_RESET));
    check("win_end", win_end, 20'(WIN_END_RESET));
    check("grant", grant, 20'h0);
    check("refuse", refuse, 20'h0);
    check("grant_addr", grant_addr, 20'h0);
    check("opt_addr", opt_addr, OPT_PRIMARY_BASE);
    @(posedge clk);
    win_set <= 1;
    win_start_in <= 8'h02;
    win_end_in <= 8'h06;
    @(posedge clk);
    win_set <= 0;
    #1 check("win", {win_start, win_end}, 20'h0206);
    foreach (rows[i]) begin
      @(posedge clk);
      self_prog <= rows[i].sp;
      boot0_protect <= rows[i].b0;
      cmd <= rows[i].c;
      cmd_addr <= {2'h0, rows[i].blk, 10'h000};
      @(posedge clk);
      cmd <= CMD_NONE;
      #1 check("grant", grant, rows[i].ok);
      check("refuse", refuse, !rows[i].ok);
      if (rows[i].ok) check("grant_addr", grant_addr, {2'h0, rows[i].blk, 10'h000});
    end
    // Every mode, swap and index combination of the option fetch
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      self_prog <= k[3];
      boot_swap <= k[2];
      opt_index <= k[1:0];
      @(posedge clk);
      #1 check("opt_addr", opt_addr, ((k[3] && k[2]) ? OPT_SWAP_BASE : OPT_PRIMARY_BASE) + 20'(k[1:0]));
      check("opt_byte", opt_byte, 20'(8'h11 * (k[1:0] + 1)));
    end
    // Window reloaded while self programming, then two commands back to back
    @(posedge clk);
    self_prog <= 1;
    boot_swap <= 0;
    opt_index <= 2'h0;
    win_set <= 1;
    win_start_in <= 8'h08;
    win_end_in <= 8'h09;
    @(posedge clk);
    win_set <= 0;
    cmd <= CMD_WRITE;
    cmd_addr <= 20'h02400;
    #1 check("win", {win_start, win_end}, 20'h0809);
    @(posedge clk);
    cmd <= CMD_ERASE;
    cmd_addr <= 20'h02800;
    #1 check("grant", grant, 20'h1);
    check("grant_addr", grant_addr, 20'h02400);
    @(posedge clk);
    cmd <= CMD_NONE;
    #1 check("refuse", refuse, 20'h1);
    check("grant", grant, 20'h0);
    // Reset in mid-run: window back to unrestricted, address cleared
    @(posedge clk);
    nrst <= 0;
    #1 check("win_start", win_start, 20'(WIN_START_RESET));
    check("win_end", win_end, 20'(WIN_END_RESET));
    check("grant_addr", grant_addr, 20'h0);
    repeat (2) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    cmd <= CMD_ERASE;
    cmd_addr <= 20'h02800;
    @(posedge clk);
    cmd <= CMD_NONE;
    #1 check("grant", grant, 20'h1);
    check("refuse", refuse, 20'h0);
    stop_test();
  end
endmodule : tb_top
